// *** rtl/hsrp_cfg.svh ***
// Constants of the host serial register port.
`ifndef HSRP_CFG_SVH
`define HSRP_CFG_SVH
`define HSRP_INSTR_BITS 5
`define HSRP_ADDR_BITS 11
`define HSRP_DATA_BITS 8
`define HSRP_HDR_BITS 16
`define HSRP_REG_DEPTH 2048
`define HSRP_REG_RESET 8'h00
`define HSRP_ACK_DLY_NS 50
`define HSRP_CLK_NS 50
`define HSRP_ACK_CYC ((`HSRP_ACK_DLY_NS + `HSRP_CLK_NS - 1) / `HSRP_CLK_NS)
`endif

// *** rtl/hsrp_pkg.sv ***
// Types of the host serial register port.
`default_nettype none
package hsrp_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  // Phases of one serial transaction.
  typedef enum logic [1:0] {HSRP_IDLE, HSRP_HDR, HSRP_RDAT, HSRP_WDAT}
    hsrp_phase_t;
endpackage : hsrp_pkg
`default_nettype wire

// *** rtl/hsrp_port.sv ***
// Serial register port with parallel strobe acknowledge.
// What this block does
// - Select fall starts, rise ends transaction.
// - Five instruction bits sampled on clock rise.
// - Instruction top bit one means read.
// - Eleven address bits follow the instruction.
// - Read data shifts out on falling edges.
// - Write data follows address, then stored.
`include "hsrp_cfg.svh"
`default_nettype none
module hsrp_port
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serialOutEn,
  input wire logic parallel_strobe_n,
  output logic ackN
);

  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  // All flip-flops of the port except the register array.
  typedef struct packed {
    logic [1:0] sclkSync;   // Serial clock synchroniser.
    logic [1:0] selSync;    // Select synchroniser.
    logic [1:0] dataSync;   // Serial input synchroniser.
    logic [1:0] strobeSync; // Strobe synchroniser.
    logic sclkPrev;         // Last synchronised serial clock.
    logic selPrev;          // Last synchronised select.
    hsrp_pkg::hsrp_phase_t phase;
    logic [4:0] bitCnt;     // Bits taken in the current phase.
    logic [15:0] hdr;       // Instruction and address.
    logic [7:0] shift;      // Data shifter.
    logic isRead;           // Transaction is a read.
    logic wrEn;             // Pulse: store shift into the array.
    logic [10:0] wrAddr;    // Address of the pending store.
    logic [7:0] wrData;     // Data of the pending store.
    logic outBit;           // Serial output level.
    logic outEn;            // Serial output enable.
    logic [1:0] ackCnt;     // Strobe low cycles seen.
    // Kept at pin level so that the pin comes straight from a flop.
    logic ackN;             // Acknowledge, low while given.
  } hsrp_state_t;

  hsrp_state_t st_r;
  hsrp_state_t st_nxt;

  // Register storage; contents are undefined until first written.
  logic [7:0] regMem [0:`HSRP_REG_DEPTH-1];
  logic [7:0] rdByte;

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------

  // Edges of the synchronised pins. The clock flops reset high, so a
  // host that idles its clock low shows one false fall after reset;
  // it is harmless because no transaction is open at that time.
  logic sclkRise;
  logic sclkFall;
  logic selFall;
  logic selRise;
  assign sclkRise = st_r.sclkSync[1] & ~st_r.sclkPrev;
  assign sclkFall = ~st_r.sclkSync[1] & st_r.sclkPrev;
  assign selFall = ~st_r.selSync[1] & st_r.selPrev;
  assign selRise = st_r.selSync[1] & ~st_r.selPrev;

  // Read port of the array. The address is the header with the bit
  // arriving now appended; it is only used on the last header bit.
  // Taking it from the flops, not from st_nxt, keeps the path free of
  // a combinational loop through the next-state process.
  assign rdByte = regMem[{st_r.hdr[9:0], st_r.dataSync[1]}];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // The whole transaction walks here; the array write is separate.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sclkSync = {st_r.sclkSync[0], serialClk};
    st_nxt.selSync = {st_r.selSync[0], selectN};
    st_nxt.dataSync = {st_r.dataSync[0], serial_in_line};
    st_nxt.strobeSync = {st_r.strobeSync[0], parallel_strobe_n};
    st_nxt.sclkPrev = st_r.sclkSync[1];
    st_nxt.selPrev = st_r.selSync[1];
    st_nxt.wrEn = 1'b0;
    if (selFall)
    begin
      st_nxt.phase = hsrp_pkg::HSRP_HDR;
      st_nxt.bitCnt = 5'h00;
    end
    else if (selRise || st_r.selSync[1])
    begin
      st_nxt.phase = hsrp_pkg::HSRP_IDLE;
      st_nxt.outEn = 1'b0;
    end
    else
    begin
      case (st_r.phase)
        hsrp_pkg::HSRP_HDR:
        begin
          if (sclkRise)
          begin
            st_nxt.hdr = {st_r.hdr[14:0], st_r.dataSync[1]};
            st_nxt.bitCnt = st_r.bitCnt + 5'h01;
            if (st_r.bitCnt == 5'(`HSRP_HDR_BITS - 1))
            begin
              st_nxt.bitCnt = 5'h00;
              st_nxt.isRead = st_r.hdr[14];
              if (st_r.hdr[14])
              begin
                st_nxt.phase = hsrp_pkg::HSRP_RDAT;
                st_nxt.shift = rdByte;
              end
              else
              begin
                st_nxt.phase = hsrp_pkg::HSRP_WDAT;
              end
            end
          end
        end
        hsrp_pkg::HSRP_RDAT:
        begin
          if (sclkFall && st_r.bitCnt < 5'(`HSRP_DATA_BITS))
          begin
            st_nxt.outEn = 1'b1;
            st_nxt.outBit = st_r.shift[7];
            st_nxt.shift = {st_r.shift[6:0], 1'b0};
            st_nxt.bitCnt = st_r.bitCnt + 5'h01;
          end
        end
        hsrp_pkg::HSRP_WDAT:
        begin
          if (sclkRise)
          begin
            st_nxt.shift = {st_r.shift[6:0], st_r.dataSync[1]};
            st_nxt.bitCnt = st_r.bitCnt + 5'h01;
            if (st_r.bitCnt == 5'(`HSRP_DATA_BITS - 1))
            begin
              st_nxt.wrEn = 1'b1;
              st_nxt.wrAddr = st_r.hdr[10:0];
              st_nxt.wrData = {st_r.shift[6:0], st_r.dataSync[1]};
              st_nxt.phase = hsrp_pkg::HSRP_IDLE;
            end
          end
        end
        default:
        begin
          st_nxt.phase = hsrp_pkg::HSRP_IDLE;
        end
      endcase
    end
    if (st_r.strobeSync[1])
    begin
      // Strobe released: withdraw the acknowledge at once.
      st_nxt.ackCnt = 2'h0;
      st_nxt.ackN = 1'b1;
    end
    else if (st_r.ackCnt < 2'(`HSRP_ACK_CYC))
    begin
      st_nxt.ackCnt = st_r.ackCnt + 2'h1;
    end
    else
    begin
      st_nxt.ackN = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  // One register for the whole state; hold the pins idle at reset.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.sclkSync <= 2'h3;
      st_r.selSync <= 2'h3;
      st_r.strobeSync <= 2'h3;
      st_r.ackN <= 1'b1;
      st_r.sclkPrev <= 1'b1;
      st_r.selPrev <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Array store; no reset so it can map onto a memory.
  always_ff @(posedge clk)
  begin
    if (st_r.wrEn)
    begin
      regMem[st_r.wrAddr] <= st_r.wrData;
    end
  end

  // Pins come straight from flops, with no gate after them.
  assign serial_out_line = st_r.outBit;
  assign serialOutEn = st_r.outEn;
  assign ackN = st_r.ackN;

endmodule : hsrp_port
`default_nettype wire

// *** verification/hsrp_port_chk.sv ***
// Checker of the host serial register port.
`default_nettype none
module hsrp_port_chk
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serialOutEn,
  input wire logic parallel_strobe_n,
  input wire logic ackN
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Serial output and strobe acknowledge properties
  // ---------------------------------------------------------------
  // Every property runs on the system clock and rests during reset.
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_oe_idle_off: assert property (selectN[*5] |-> !serialOutEn)
    else $error("output enabled while deselected");
  chk_oe_rise_sel: assert property ($rose(serialOutEn) |-> !selectN)
    else $error("output enabled outside a frame");
  chk_oe_rise_low: assert property ($rose(serialOutEn) |-> !serialClk)
    else $error("output enabled away from a falling edge");
  chk_oe_hold_sel: assert property (serialOutEn && !selectN |=> serialOutEn)
    else $error("output enable dropped inside a frame");
  chk_out_hold_high: assert property
    ((!selectN && serialClk)[*4] |-> $stable(serial_out_line))
    else $error("serial output moved while clock high");
  chk_ack_on_strobe: assert property
    ($fell(parallel_strobe_n) |-> ##[1:6] !ackN)
    else $error("acknowledge late");
  chk_ack_off_idle: assert property (parallel_strobe_n[*5] |-> ackN)
    else $error("acknowledge without strobe");
  // The host may let go of the strobe on the edge that shows the
  // acknowledge, so the cause is looked for one sample earlier.
  chk_ack_fall_cause: assert property
    ($fell(ackN) |-> !$past(parallel_strobe_n))
    else $error("acknowledge fell with strobe high");
endmodule : hsrp_port_chk
// The checker sits inside every port and watches its pins only.
bind hsrp_port hsrp_port_chk i_hsrp_port_chk (.clk(clk), .nrst(nrst),
  .serialClk(serialClk), .selectN(selectN), .serial_in_line(serial_in_line),
  .serial_out_line(serial_out_line), .serialOutEn(serialOutEn),
  .parallel_strobe_n(parallel_strobe_n), .ackN(ackN));
`default_nettype wire

// *** verification/hsrp_host_model.sv ***
// Host side model: frames serial transfers and strobes.
`default_nettype none
module hsrp_host_model
(
  input wire logic clk,
  output logic serialClk,
  output logic selectN,
  output logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serialOutEn,
  output logic parallel_strobe_n,
  input wire logic ackN
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock idles low, so it stands still between frames.
  initial
  begin
    {serialClk, selectN, serial_in_line, parallel_strobe_n} = 4'h5;
  end
  task automatic xfer(input logic [15:0] hdr, input logic [7:0] wd,
    input int n, output logic [7:0] rd, output logic oe);
    logic [23:0] sh;
    sh = {hdr, wd};
    oe = 0;
    rd = 0;
    selectN = 0;
    for (int b = 0; b < n; b++)
    begin
      serialClk = 0;
      serial_in_line = sh[23 - b];
      repeat (4) @(negedge clk);
      serialClk = 1;
      repeat (4) @(negedge clk);
      oe |= serialOutEn;
      // A line left undriven reads as high impedance, never as a lucky bit.
      rd = {rd[6:0], serialOutEn ? serial_out_line : 1'bz};
    end
    serialClk = 0;
    serial_in_line = ~serial_in_line;
    repeat (4) @(negedge clk);
    selectN = 1;
    repeat (8) @(negedge clk);
  endtask : xfer
  task automatic strobe(output logic ok);
    ok = 0;
    parallel_strobe_n = 0;
    // Look at the acknowledge between rising edges, where it is settled.
    for (int c = 0; c < 20 && !ok; c++)
    begin
      @(negedge clk);
      ok = (ackN === 1'b0);
    end
    // Let go at the edge that showed the acknowledge, as a host may.
    parallel_strobe_n = 1;
    repeat (6) @(negedge clk);
  endtask : strobe
endmodule : hsrp_host_model
`default_nettype wire

// *** verification/hsrp_port_bench.sv ***
// Self-checking bench of the host serial register port.
`default_nettype none
module hsrp_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Clock, reset and the two sides of the port
  // ---------------------------------------------------------------
  logic clk = 0;
  logic nrst = 0;
  // Pins between the host model and the port; ackN is active low.
  logic sck, sel, din, dout, doutEn, stb, ackN;
  int failures = 0;
  int samples_checked = 0;
  // A 25 ns half period gives the 50 ns system clock.
  always #25 clk = ~clk;
  hsrp_port i_hsrp_port (.clk(clk), .nrst(nrst), .serialClk(sck),
    .selectN(sel), .serial_in_line(din), .serial_out_line(dout),
    .serialOutEn(doutEn), .parallel_strobe_n(stb), .ackN(ackN));
  hsrp_host_model i_hsrp_host_model (.clk(clk), .serialClk(sck),
    .selectN(sel), .serial_in_line(din), .serial_out_line(dout),
    .serialOutEn(doutEn), .parallel_strobe_n(stb), .ackN(ackN));
  // ---------------------------------------------------------------
  // Expectations and reporting
  // ---------------------------------------------------------------
  // Only a read, instruction top bit one, may enable the output.
  function automatic logic [7:0] drives_out(input logic [4:0] instr);
    return {7'h00, instr[4]};
  endfunction : drives_out
  // Case inequality, so that an unknown value never passes.
  task check(input logic [7:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task end_sim;
    $display("failures %0d checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  initial
  begin
    logic [7:0] mem [0:2047];
    logic [7:0] rd;
    logic [10:0] a;
    logic [4:0] ins;
    logic oe, ok;
    int seed;
    seed = 23;
    repeat (10) @(negedge clk);
    nrst = 1;
    repeat (4) @(negedge clk);
    // Edge addresses and data first, then random ones.
    for (int i = 0; i < 12; i++)
    begin
      a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($random(seed));
      mem[a] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      // Low instruction bits are random on both kinds: they are ignored.
      ins = {1'b0, 4'($random(seed))};
      i_hsrp_host_model.xfer({ins, a}, mem[a], 24, rd, oe);
      check(8'(oe), drives_out(ins), "write enable");
      ins = {1'b1, 4'($random(seed))};
      i_hsrp_host_model.xfer({ins, a}, 8'h00, 24, rd, oe);
      check(rd, mem[a], "read data");
      check(8'(oe), drives_out(ins), "read enable");
    end
    // A frame cut short must leave the register alone.
    i_hsrp_host_model.xfer({5'h00, a}, ~mem[a], 20, rd, oe);
    check(8'(oe), drives_out(5'h00), "aborted enable");
    i_hsrp_host_model.xfer({5'h10, a}, 8'h00, 24, rd, oe);
    check(rd, mem[a], "aborted write");
    i_hsrp_host_model.strobe(ok);
    check(8'(ok), 8'h01, "strobe acknowledge");
    end_sim;
  end
endmodule : hsrp_port_bench
`default_nettype wire
